// ---- dmd_pkg.sv ----
package dmd_pkg;
	localparam int MAIN_W      = 12;
	localparam int SWALLOW_W   = 7;
	localparam int LEAD_BITS   = 4;
	localparam int SINGLE_BITS = 16;
	localparam int DUAL_BITS   = 24;
	localparam logic [7:0] DEV_ADDR_LOW   = 8'h62;
	localparam logic [7:0] SUB_MAIN       = 8'h01;
	localparam logic [7:0] SUB_STATUS     = 8'h02;
	localparam int DOUBLER_BIT            = 7;
	localparam int COUNTERS_ON_BIT        = 1;
	localparam logic [7:0] STATUS_RESET   = 8'h00;
	localparam logic [11:0] MAIN_RESET    = 12'h001;
	localparam logic [6:0] SWALLOW_RESET  = 7'h00;
	localparam int SWALLOW_ZERO_COUNT     = 128;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_SUB  = 3'b010,
		ST_DATA = 3'b011,
		ST_SKIP = 3'b100
	} dmd_bus_state_t;
endpackage

// ---- dmd_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
module dmd_counter
	import dmd_pkg::*;
(
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 arst_n,
	// Control
	input  wire logic                 vco_edge,
	input  wire logic                 enable,
	input  wire logic                 dual_mode,
	input  wire logic [MAIN_W-1:0]    main_value,
	input  wire logic [SWALLOW_W-1:0] swallow_value,
	// Outputs
	output logic                      prescaler_modulus_select,
	output logic                      divider_pulse
);
	logic [MAIN_W-1:0]    main_reg, main_next;
	logic [SWALLOW_W:0]   swal_reg, swal_next;
	logic                 mod_reg, mod_next, pulse_reg, pulse_next;

	// Zero swallow means a full 128 count
	function automatic logic [SWALLOW_W:0] swal_load(input logic [SWALLOW_W-1:0] v);
		swal_load = (v == '0) ? (SWALLOW_W+1)'(SWALLOW_ZERO_COUNT) : {1'b0, v};
	endfunction

	always_comb
	begin
		main_next  = main_reg;
		swal_next  = swal_reg;
		mod_next   = mod_reg;
		pulse_next = 1'b0;
		if (enable && vco_edge)
		begin
			if (main_reg <= 12'h001)
			begin
				// Terminal count reloads both counters
				main_next  = main_value;
				swal_next  = swal_load(swallow_value);
				mod_next   = ~dual_mode;
				pulse_next = 1'b1;
			end
			else
			begin
				main_next = main_reg - 12'h001;
				if (dual_mode && swal_reg != '0)
				begin
					swal_next = swal_reg - 8'h01;
					mod_next  = (swal_reg == 8'h01);
				end
				else
					mod_next = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			main_reg  <= MAIN_RESET;
			swal_reg  <= 8'h00;
			mod_reg   <= 1'b1;
			pulse_reg <= 1'b0;
		end
		else
		begin
			main_reg  <= main_next;
			swal_reg  <= swal_next;
			mod_reg   <= mod_next;
			pulse_reg <= pulse_next;
		end
	end

	assign prescaler_modulus_select = mod_reg;
	assign divider_pulse            = pulse_reg;

	property p_mod_low_while_swallow;
		@(posedge ref_clk) disable iff (!arst_n)
		(dual_mode && swal_reg > 8'h01 && main_reg > 12'h001 && enable && vco_edge) |=> !mod_reg;
	endproperty
	a_mod_low_while_swallow: assert property (p_mod_low_while_swallow) else $error("select not low while swallowing");

	property p_reload;
		@(posedge ref_clk) disable iff (!arst_n)
		(enable && vco_edge && main_reg <= 12'h001) |=> (main_reg == $past(main_value) && divider_pulse);
	endproperty
	a_reload: assert property (p_reload) else $error("main divider did not reload");

	property p_single_high;
		@(posedge ref_clk) disable iff (!arst_n)
		(!dual_mode && enable && vco_edge) |=> mod_reg;
	endproperty
	a_single_high: assert property (p_single_high) else $error("select low in single mode");

	property p_zero_swallow;
		@(posedge ref_clk) disable iff (!arst_n)
		(enable && vco_edge && main_reg <= 12'h001 && swallow_value == 7'h00) |=> swal_reg == 8'h80;
	endproperty
	a_zero_swallow: assert property (p_zero_swallow) else $error("zero swallow not loaded as 128");

	property p_hold_no_edge;
		@(posedge ref_clk) disable iff (!arst_n)
		!vco_edge |=> $stable(main_reg) && $stable(mod_reg);
	endproperty
	a_hold_no_edge: assert property (p_hold_no_edge) else $error("counter moved without input edge");
endmodule
`default_nettype wire

// ---- dmd_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module dmd_top
	import dmd_pkg::*;
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic arst_n,
	// Serial bus pins
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe_n,
	// Mode pin and divided input
	input  wire logic dual_mode_pin,
	input  wire logic divided_vco_input,
	// Outputs
	output logic      prescaler_modulus_select,
	output logic      divider_pulse,
	output logic      doubler_on,
	output logic      counters_on
);
	////////////////////////////////////////////////////////////////////////
	// Synchronisers
	logic [1:0] scl_s, sda_s, mode_s, vco_s;
	logic       scl_d, sda_d, vco_d;
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			mode_s <= 2'h0;
			vco_s <= 2'h0;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			vco_d <= 1'b0;
		end
		else
		begin
			scl_s <= {scl_s[0], scl_in};
			sda_s <= {sda_s[0], sda_in};
			mode_s <= {mode_s[0], dual_mode_pin};
			vco_s <= {vco_s[0], divided_vco_input};
			scl_d <= scl_s[1];
			sda_d <= sda_s[1];
			vco_d <= vco_s[1];
		end
	end
	logic scl, sda, dual_mode, scl_rise, scl_fall, start_ev, stop_ev, vco_edge;
	assign scl      = scl_s[1];
	assign sda      = sda_s[1];
	assign dual_mode = mode_s[1];
	assign scl_rise = scl & ~scl_d;
	assign scl_fall = ~scl & scl_d;
	assign start_ev = scl & scl_d & sda_d & ~sda;
	assign stop_ev  = scl & scl_d & ~sda_d & sda;
	assign vco_edge = vco_s[1] & ~vco_d;

	////////////////////////////////////////////////////////////////////////
	// Bus receiver
	dmd_bus_state_t st_reg, st_next;
	logic [7:0]  sh_reg, sh_next, sub_reg, sub_next;
	logic [3:0]  bit_reg, bit_next;
	logic [1:0]  nbytes_reg, nbytes_next;
	logic [23:0] data_reg, data_next;
	logic        ack_reg, ack_next;
	logic        pend_reg, pend_next;
	logic [7:0]  status_reg, status_next;
	logic [MAIN_W-1:0]    main_val_reg, main_val_next;
	logic [SWALLOW_W-1:0] swal_val_reg, swal_val_next;

	function automatic logic [1:0] bytes_needed(input logic [7:0] sub, input logic dm);
		if (sub == SUB_STATUS)
			bytes_needed = 2'd1;
		else if (sub == SUB_MAIN)
			bytes_needed = dm ? 2'd3 : 2'd2;
		else
			bytes_needed = 2'd0;
	endfunction

	always_comb
	begin
		st_next       = st_reg;
		sh_next       = sh_reg;
		sub_next      = sub_reg;
		bit_next      = bit_reg;
		nbytes_next   = nbytes_reg;
		data_next     = data_reg;
		ack_next      = ack_reg;
		pend_next     = pend_reg;
		status_next   = status_reg;
		main_val_next = main_val_reg;
		swal_val_next = swal_val_reg;
		if (start_ev || stop_ev)
		begin
			// Latch only complete, checked messages
			if (pend_reg && nbytes_reg == bytes_needed(sub_reg, dual_mode))
			begin
				if (sub_reg == SUB_STATUS)
					status_next = data_reg[7:0];
				else if (dual_mode)
				begin
					swal_val_next = data_reg[18:12];
					main_val_next = data_reg[11:0];
				end
				else
					main_val_next = data_reg[11:0];
			end
			pend_next   = 1'b0;
			nbytes_next = 2'd0;
			bit_next    = 4'd0;
			ack_next    = 1'b0;
			st_next     = start_ev ? ST_ADDR : ST_IDLE;
		end
		else
		begin
			// The acknowledge clock carries no data bit, so it must not be shifted in
			if (scl_rise && st_reg != ST_IDLE && st_reg != ST_SKIP && bit_reg < 4'd8 && !ack_reg)
			begin
				sh_next  = {sh_reg[6:0], sda};
				bit_next = bit_reg + 4'd1;
			end
			if (scl_fall && bit_reg == 4'd8 && !ack_reg)
			begin
				bit_next = 4'd0;
				case (st_reg)
					ST_ADDR:
						if (sh_reg == {dual_mode, DEV_ADDR_LOW[6:0]})
						begin
							ack_next = 1'b1;
							st_next  = ST_SUB;
						end
						else
							st_next = ST_SKIP;
					ST_SUB:
					begin
						sub_next = sh_reg;
						ack_next = 1'b1;
						st_next  = ST_DATA;
					end
					ST_DATA:
						if (nbytes_reg < bytes_needed(sub_reg, dual_mode))
						begin
							data_next   = {data_reg[15:0], sh_reg};
							nbytes_next = nbytes_reg + 2'd1;
							pend_next   = 1'b1;
							ack_next    = 1'b1;
						end
						else
						begin
							pend_next = 1'b0; // Too many bytes spoils the message
							st_next   = ST_SKIP;
						end
					default:
						st_next = ST_SKIP;
				endcase
			end
			else if (scl_fall && ack_reg)
				ack_next = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_reg       <= ST_IDLE;
			sh_reg       <= 8'h00;
			sub_reg      <= 8'h00;
			bit_reg      <= 4'h0;
			nbytes_reg   <= 2'h0;
			data_reg     <= 24'h000000;
			ack_reg      <= 1'b0;
			pend_reg     <= 1'b0;
			status_reg   <= STATUS_RESET;
			main_val_reg <= MAIN_RESET;
			swal_val_reg <= SWALLOW_RESET;
		end
		else
		begin
			st_reg       <= st_next;
			sh_reg       <= sh_next;
			sub_reg      <= sub_next;
			bit_reg      <= bit_next;
			nbytes_reg   <= nbytes_next;
			data_reg     <= data_next;
			ack_reg      <= ack_next;
			pend_reg     <= pend_next;
			status_reg   <= status_next;
			main_val_reg <= main_val_next;
			swal_val_reg <= swal_val_next;
		end
	end

	// Open drain: only ever pulls low
	assign sda_out     = 1'b0;
	assign sda_oe_n    = ~ack_reg;
	assign doubler_on  = status_reg[DOUBLER_BIT];
	assign counters_on = status_reg[COUNTERS_ON_BIT];

	////////////////////////////////////////////////////////////////////////
	// Divider
	dmd_counter u_counter
	(
		.ref_clk                  (ref_clk),
		.arst_n                   (arst_n),
		.vco_edge                 (vco_edge),
		.enable                   (counters_on),
		.dual_mode                (dual_mode),
		.main_value               (main_val_reg),
		.swallow_value            (swal_val_reg),
		.prescaler_modulus_select (prescaler_modulus_select),
		.divider_pulse            (divider_pulse)
	);

	property p_latch_only_on_cond;
		@(posedge ref_clk) disable iff (!arst_n)
		!(start_ev || stop_ev) |=> $stable(main_val_reg) && $stable(swal_val_reg);
	endproperty
	a_latch_only_on_cond: assert property (p_latch_only_on_cond) else $error("divider latched outside stop or start");

	property p_checked;
		@(posedge ref_clk) disable iff (!arst_n)
		((start_ev || stop_ev) && nbytes_reg != bytes_needed(sub_reg, dual_mode)) |=> $stable(main_val_reg);
	endproperty
	a_checked: assert property (p_checked) else $error("incomplete message updated divider");

	property p_addr_match;
		@(posedge ref_clk) disable iff (!arst_n)
		(st_reg == ST_ADDR && scl_fall && bit_reg == 4'd8 && sh_reg[7] != dual_mode) |=> !ack_reg;
	endproperty
	a_addr_match: assert property (p_addr_match) else $error("wrong mode address acknowledged");

	property p_doubler;
		@(posedge ref_clk) disable iff (!arst_n)
		((start_ev || stop_ev) && pend_reg && sub_reg == SUB_STATUS && nbytes_reg == 2'd1)
			|=> (doubler_on == $past(data_reg[DOUBLER_BIT]));
	endproperty
	a_doubler: assert property (p_doubler) else $error("doubler not following status bit");
endmodule
`default_nettype wire

// ---- dmd_i2c_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module dmd_i2c_master
(
	// Clock
	input  wire logic ref_clk,
	// Bus lines
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_drv
);
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// Data moves only while the clock is low, well clear of its edges
	task automatic clk_bit(input logic b, output logic seen);
		wt(4);
		sda_drv = b;
		wt(4);
		scl = 1'b1;
		wt(8);
		seen = sda_line;
		scl = 1'b0;
	endtask
	// Also serves as a repeated start when the clock is still held low
	task automatic start_cond();
		wt(4);
		sda_drv = 1'b1;
		wt(4);
		scl = 1'b1;
		wt(8);
		sda_drv = 1'b0;
		wt(8);
		scl = 1'b0;
	endtask
	task automatic stop_cond();
		wt(4);
		sda_drv = 1'b0;
		wt(4);
		scl = 1'b1;
		wt(8);
		sda_drv = 1'b1;
		wt(8);
	endtask
	// Address, sub-address, then n data bytes, each MSB first
	task automatic send_msg(input logic [7:0] addr, input logic [7:0] sub, input int n,
		input logic [23:0] data, input bit do_stop, output int acks);
		logic [39:0] bits;
		logic        seen;
		acks = 0;
		bits = {addr, sub, data << (8 * (3 - n))};
		start_cond();
		for (int i = 0; i < 8 * (n + 2); i++)
		begin
			clk_bit(bits[39-i], seen);
			if (i % 8 == 7)
			begin
				clk_bit(1'b1, seen);
				acks += (seen === 1'b0) ? 1 : 0;
			end
		end
		if (do_stop)
			stop_cond();
	endtask
endmodule
`default_nettype wire

// ---- dual_modulus_divider_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module dual_modulus_divider_control_tb
	import dmd_pkg::*;
;
	logic ref_clk;
	logic arst_n;
	logic dual_mode_pin;
	logic divided_vco_input;
	wire  scl;
	wire  sda_drv;
	wire  sda_line;
	logic sda_out;
	logic sda_oe_n;
	logic sel;
	logic pulse;
	logic dbl;
	logic con;
	int   bad_count = 0;
	int   compares = 0;
	int   cycles = 0;
	int   edges_since = 0;
	int   lows_since = 0;
	int   last_period = 0;
	int   last_lows = 0;
	int   acks;
	// Open-drain data line with pull-up
	assign sda_line = sda_drv & (sda_oe_n | sda_out);
	dmd_top dut (.ref_clk(ref_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .dual_mode_pin(dual_mode_pin), .divided_vco_input(divided_vco_input),
		.prescaler_modulus_select(sel), .divider_pulse(pulse), .doubler_on(dbl), .counters_on(con));
	dmd_i2c_master m (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
	always #5 ref_clk = ~ref_clk;
	////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("checks %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			bad_count++;
			stop_test();
		end
	end
	// Each reload latches the edge count and low-select count of the period just ended;
	// looked at on the falling edge, where the registered pulse has settled
	always @(negedge ref_clk)
	begin
		if (pulse === 1'b1)
		begin
			last_period = edges_since;
			last_lows = lows_since;
			edges_since = 0;
			lows_since = 0;
		end
	end
	task automatic wt(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// Select is sampled as it stands over the input cycle that the edge closes
	task automatic run_div(input int n);
		repeat (n)
		begin
			@(negedge ref_clk);
			edges_since++;
			lows_since += (sel === 1'b0) ? 1 : 0;
			divided_vco_input = 1'b1;
			wt(4);
			divided_vco_input = 1'b0;
			wt(3);
		end
		wt(8);
	endtask
	task automatic msg(input logic [7:0] sub, input int n, input logic [23:0] d, input bit st,
		input int exp_acks, input logic b7);
		m.send_msg({b7, DEV_ADDR_LOW[6:0]}, sub, n, d, st, acks);
		if (exp_acks >= 0)
			`CHK("acks", exp_acks, acks)
		wt(10);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		`CHK("doubler", 1'b0, dbl)
		`CHK("select", 1'b1, sel)
		`CHK("pulse", 1'b0, pulse)
		$display("test reset done");
	endtask
	task automatic t_status();
		msg(SUB_STATUS, 1, 24'h000082, 1, 3, 1'b0);
		`CHK("doubler", 1'b1, dbl)
		`CHK("counters", 1'b1, con)
		$display("test status done");
	endtask
	task automatic t_single();
		msg(SUB_MAIN, 2, 24'h00F005, 1, 4, 1'b0);
		run_div(15);
		`CHK("period", 5, last_period)
		`CHK("lows", 0, last_lows)
		$display("test single done");
	endtask
	// Foreign address, extra byte and short message must all leave N alone
	task automatic t_refuse();
		msg(SUB_MAIN, 2, 24'h000007, 1, 0, 1'b1);
		msg(SUB_MAIN, 3, 24'h000009, 1, 4, 1'b0);
		msg(SUB_MAIN, 1, 24'h00000B, 1, 3, 1'b0);
		msg(8'h05, 2, 24'h00000D, 1, 2, 1'b0);
		run_div(15);
		`CHK("period", 5, last_period)
		$display("test refuse done");
	endtask
	task automatic t_hold_dual();
		msg(SUB_STATUS, 1, 24'h000002, 0, 3, 1'b0);
		wt(40);
		`CHK("doubler", 1'b1, dbl)
		dual_mode_pin = 1'b1;
		msg(SUB_MAIN, 3, {5'h00, 7'd3, 12'd10}, 1, 5, 1'b1);
		`CHK("doubler", 1'b0, dbl)
		run_div(30);
		`CHK("period", 10, last_period)
		`CHK("lows", 3, last_lows)
		$display("test hold_dual done");
	endtask
	task automatic t_zero();
		msg(SUB_MAIN, 3, {5'h00, 7'd0, 12'd130}, 1, 5, 1'b1);
		run_div(390);
		`CHK("period", 130, last_period)
		`CHK("lows", SWALLOW_ZERO_COUNT, last_lows)
		$display("test zero done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		ref_clk = 1'b0;
		arst_n = 1'b0;
		dual_mode_pin = 1'b0;
		divided_vco_input = 1'b0;
		wt(5);
		arst_n = 1'b1;
		wt(3);
		t_reset();
		t_status();
		t_single();
		t_refuse();
		t_hold_dual();
		t_zero();
		stop_test();
	end
endmodule
`default_nettype wire
